// ### hw/phy_cfg.svh
`ifndef PHY_CFG_SVH
`define PHY_CFG_SVH

`define FE_CFG_ADDR 16'h0043
`define SKEW_STS_ADDR 16'h0055
`define STRAP_A_ADDR 16'h006E
`define STRAP_B_ADDR 16'h006F

`define FE_CFG_RESET 16'h07A0
`define FE_CFG_WMASK 16'h0FF7

`define CUTOFF_OFF_BIT 11
`define RECOVERY_MSB 10
`define RECOVERY_LSB 7
`define FORCE_LINK_BIT 6
`define TERNARY_BIT 5
`define GAP_BIT 4
`define SCR_BYPASS_BIT 2
`define ODD_NIBBLE_BIT 1
`define EARLY_VALID_BIT 0

`define SKEW_B_MSB 7
`define SKEW_B_LSB 4
`define SKEW_A_MSB 3
`define SKEW_A_LSB 0
`define SKEW_W 4

`define ST_A_MIRROR_BIT 15
`define ST_A_DOWNSHIFT_BIT 14
`define ST_A_CLK_OUT_BIT 13
`define ST_A_PAR_MAC_BIT 12
`define ST_A_SER_MAC_BIT 11
`define ST_A_AUTO_X_BIT 10
`define ST_A_FORCE_X_BIT 9
`define ST_A_HALF_DUP_BIT 8
`define ST_A_NEG_OFF_BIT 7
`define ST_A_NEG_SEL_BIT 5
`define ST_A_ADDR_MSB 3
`define ST_A_ADDR_LSB 0
`define ST_B_QLD_BIT 10
`define ST_B_TX_MSB 6
`define ST_B_TX_LSB 4
`define ST_B_RX_MSB 2
`define ST_B_RX_LSB 0

`define CLK_FREQ_MHZ 20
`define CUTOFF_TIME_US 1500
`define MS_TIME_US 1000
`define TIMER_W 24

`endif

// ### hw/phy_cfg_pkg.sv
package phy_cfg_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic mirror_on;
        logic downshift_on;
        logic latched_clock_output_off;
        logic latched_parallel_mac_off;
        logic serial_mac_on;
        logic latched_auto_crossover_off;
        logic latched_forced_crossover;
        logic latched_half_duplex;
        logic latched_negotiation_off;
        logic latched_negotiation_select;
        logic [3:0] latched_port_address;
        logic latched_quick_link_drop_on;
        logic [2:0] tx_delay_low;
        logic [2:0] rx_delay_low;
    } strap_pins_t;

    typedef struct packed {
        logic descrambler_cutoff_off;
        logic [3:0] descrambler_recovery_ms;
        logic force_good_link;
        logic enhanced_ternary_detect_on;
        logic enhanced_gap_detect_on;
        logic scrambler_bypass;
        logic odd_nibble_detect_on;
        logic early_receive_valid;
    } fe_ctrl_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_RUN = 2'b01,
        RX_CUT = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic counting;
        logic [3:0] cnt;
        logic [3:0] skew;
    } skew_state_t;

endpackage

// ### hw/pair_skew_meter.sv
`timescale 1ns/10ps
`default_nettype none

module pair_skew_meter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic ref_start,
    input wire logic pair_start,
    output logic [3:0] skew
);

    phy_cfg_pkg::skew_state_t q;
    phy_cfg_pkg::skew_state_t n;

    // The count saturates so a lost pair marker cannot wrap into a small, plausible skew.
    always_comb begin
        n = q;
        if (ref_start) begin
            n.cnt = 4'h1;
            n.counting = 1'b1;
        end else if (q.counting && q.cnt != 4'hF) begin
            n.cnt = q.cnt + 4'h1;
        end
        if (pair_start && (ref_start || q.counting)) begin
            n.skew = ref_start ? 4'h0 : q.cnt;
            n.counting = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= n;
        end
    end

    assign skew = q.skew;

endmodule // pair_skew_meter

`default_nettype wire

// ### hw/phy_config_strap_status.sv
// Operation
// R1: Bit 11 zero aborts packets over 1.5 ms.
// R2: Bits 10:7 set recovery time in ms.
// R3: Bit 6 forces a good 100 Mbps link.
// R4: Bit 5 enables enhanced ternary detection.
// R5: Bit 4 enables enhanced gap detection.
// R6: Bit 2 bypasses the transmit scrambler.
// R7: Bit 1 flags packets with odd nibbles.
// R8: Bit 0 enables early receive valid.
// R9: Skew bits 7:4 report pair B delay.
// R10: Skew bits 3:0 report pair A delay.
// R11: Status A bit 15 shows mirroring strap.
// R12: Status A bit 14 shows downshift strap.
// R13: Status A bit 13 shows clock-output-off strap.
// R14: Status A bits 12:11 show MAC straps.
// R15: Status A bits 10:9 show crossover straps.
// R16: Status A bits 8:7 show duplex, negotiation.
// R17: Status A bit 5 shows negotiation select.
// R18: Status A bits 3:0 show port address.
// R19: Status B bit 10 shows quick-drop strap.
// R20: Status B bits 6:4 show transmit delay.
// R21: Status B bits 2:0 show receive delay.
// R22: Delay codes are quarter-nanosecond four-bit steps.
// R23: Reserved bits read zero, ignore writes.
// R24: Straps captured once after reset, then held.
`include "phy_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module phy_config_strap_status #(
    parameter int CUTOFF_CYCLES = `CUTOFF_TIME_US * `CLK_FREQ_MHZ,
    parameter int MS_CYCLES = `MS_TIME_US * `CLK_FREQ_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire phy_cfg_pkg::reg_req_t req,
    output logic [15:0] rdata,
    input wire phy_cfg_pkg::strap_pins_t strap_pins,
    input wire logic rx_active,
    input wire logic rx_nibble_valid,
    input wire logic descrambler_lost,
    input wire logic link_eval_good,
    input wire logic sym_ref,
    input wire logic [1:0] pair_sym_start,
    output phy_cfg_pkg::fe_ctrl_t ctrl,
    output logic rx_abort,
    output logic descrambler_recovering,
    output logic odd_nibble_seen,
    output logic link_good_100,
    output phy_cfg_pkg::strap_pins_t latched_straps,
    output logic [3:0] tx_delay_code,
    output logic [3:0] rx_delay_code
);

    localparam logic [`TIMER_W-1:0] CUT_LAST = `TIMER_W'(CUTOFF_CYCLES - 1);
    localparam logic [`TIMER_W-1:0] MS_LAST = `TIMER_W'(MS_CYCLES - 1);

    typedef struct packed {
        logic [15:0] fe_cfg;
        phy_cfg_pkg::strap_pins_t strap_s1;
        phy_cfg_pkg::strap_pins_t strap_s2;
        phy_cfg_pkg::strap_pins_t strap_lat;
        logic [1:0] fill;
        logic captured;
        logic [15:0] rdata;
        phy_cfg_pkg::rx_state_t rx_state;
        logic [`TIMER_W-1:0] cut_cnt;
        logic abort;
        logic recov;
        logic [`TIMER_W-1:0] ms_cnt;
        logic [3:0] ms_left;
        logic nib_parity;
        logic odd_seen;
        logic link_good;
    } bank_state_t;

    bank_state_t q;
    bank_state_t n;
    logic [`SKEW_W-1:0] pair_skew [2];

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] target);
        addr_hit = (a == target);
    endfunction

    function automatic logic [15:0] strap_word_a(input phy_cfg_pkg::strap_pins_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[`ST_A_MIRROR_BIT] = s.mirror_on; // R11
        w[`ST_A_DOWNSHIFT_BIT] = s.downshift_on; // R12
        w[`ST_A_CLK_OUT_BIT] = s.latched_clock_output_off; // R13
        w[`ST_A_PAR_MAC_BIT] = s.latched_parallel_mac_off; // R14
        w[`ST_A_SER_MAC_BIT] = s.serial_mac_on; // R14
        w[`ST_A_AUTO_X_BIT] = s.latched_auto_crossover_off; // R15
        w[`ST_A_FORCE_X_BIT] = s.latched_forced_crossover; // R15
        w[`ST_A_HALF_DUP_BIT] = s.latched_half_duplex; // R16
        w[`ST_A_NEG_OFF_BIT] = s.latched_negotiation_off; // R16
        w[`ST_A_NEG_SEL_BIT] = s.latched_negotiation_select; // R17
        w[`ST_A_ADDR_MSB:`ST_A_ADDR_LSB] = s.latched_port_address; // R18
        strap_word_a = w;
    endfunction

    function automatic logic [15:0] strap_word_b(input phy_cfg_pkg::strap_pins_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[`ST_B_QLD_BIT] = s.latched_quick_link_drop_on; // R19
        w[`ST_B_TX_MSB:`ST_B_TX_LSB] = s.tx_delay_low; // R20
        w[`ST_B_RX_MSB:`ST_B_RX_LSB] = s.rx_delay_low; // R21
        strap_word_b = w;
    endfunction

    // Pair 0 is channel A and pair 1 is channel B, both timed against the common reference.
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pair
            pair_skew_meter u_meter (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .ref_start(sym_ref),
                .pair_start(pair_sym_start[i]),
                .skew(pair_skew[i])
            );
        end
    endgenerate

    always_comb begin
        n = q;

        // Strap pins are asynchronous, so they pass two flops before anything reads them.
        n.strap_s1 = strap_pins;
        n.strap_s2 = q.strap_s1;
        if (q.fill != 2'h2) begin
            n.fill = q.fill + 2'h1;
        end
        if (!q.captured && q.fill == 2'h2) begin
            n.strap_lat = q.strap_s2; // R24
            n.captured = 1'b1; // R24
        end

        n.rdata = 16'h0000;
        if (req.rd) begin
            if (addr_hit(req.addr, `FE_CFG_ADDR)) begin
                n.rdata = q.fe_cfg;
            end else if (addr_hit(req.addr, `SKEW_STS_ADDR)) begin
                n.rdata[`SKEW_B_MSB:`SKEW_B_LSB] = pair_skew[1]; // R9
                n.rdata[`SKEW_A_MSB:`SKEW_A_LSB] = pair_skew[0]; // R10
            end else if (addr_hit(req.addr, `STRAP_A_ADDR)) begin
                n.rdata = strap_word_a(q.strap_lat);
            end else if (addr_hit(req.addr, `STRAP_B_ADDR)) begin
                n.rdata = strap_word_b(q.strap_lat);
            end
        end
        if (req.wr && addr_hit(req.addr, `FE_CFG_ADDR)) begin
            n.fe_cfg = req.wdata & `FE_CFG_WMASK; // R23
        end

        // A packet that outlives the cutoff is dropped until the receiver goes idle again.
        case (q.rx_state)
            phy_cfg_pkg::RX_IDLE: begin
                n.cut_cnt = '0;
                if (rx_active) begin
                    n.rx_state = phy_cfg_pkg::RX_RUN;
                end
            end
            phy_cfg_pkg::RX_RUN: begin
                if (!rx_active) begin
                    n.rx_state = phy_cfg_pkg::RX_IDLE;
                end else if (!q.fe_cfg[`CUTOFF_OFF_BIT] && q.cut_cnt >= CUT_LAST) begin
                    n.rx_state = phy_cfg_pkg::RX_CUT; // R1
                end else if (q.cut_cnt != CUT_LAST) begin
                    n.cut_cnt = q.cut_cnt + `TIMER_W'(1);
                end
            end
            phy_cfg_pkg::RX_CUT: begin
                if (!rx_active) begin
                    n.rx_state = phy_cfg_pkg::RX_IDLE;
                end
            end
            default: begin
                n.rx_state = phy_cfg_pkg::RX_IDLE;
            end
        endcase
        n.abort = (q.rx_state == phy_cfg_pkg::RX_RUN) && (n.rx_state == phy_cfg_pkg::RX_CUT); // R1

        // The recovery length is taken when lock is lost; a later write applies to the next loss.
        if (descrambler_lost) begin
            n.ms_cnt = '0;
            n.ms_left = q.fe_cfg[`RECOVERY_MSB:`RECOVERY_LSB]; // R2
            n.recov = (q.fe_cfg[`RECOVERY_MSB:`RECOVERY_LSB] != 4'h0); // R2
        end else if (q.recov) begin
            if (q.ms_cnt >= MS_LAST) begin
                n.ms_cnt = '0;
                n.ms_left = q.ms_left - 4'h1; // R2
                n.recov = (q.ms_left != 4'h1);
            end else begin
                n.ms_cnt = q.ms_cnt + `TIMER_W'(1);
            end
        end

        n.odd_seen = 1'b0;
        if (q.rx_state == phy_cfg_pkg::RX_IDLE) begin
            n.nib_parity = rx_nibble_valid;
        end else if (!rx_active) begin
            n.odd_seen = q.fe_cfg[`ODD_NIBBLE_BIT] && q.nib_parity; // R7
            n.nib_parity = 1'b0;
        end else if (rx_nibble_valid) begin
            n.nib_parity = ~q.nib_parity; // R7
        end

        n.link_good = q.fe_cfg[`FORCE_LINK_BIT] | link_eval_good; // R3
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.fe_cfg <= `FE_CFG_RESET;
            q.rx_state <= phy_cfg_pkg::RX_IDLE;
        end else if (ce) begin
            q <= n;
        end
    end

    assign rdata = q.rdata;
    assign rx_abort = q.abort;
    assign descrambler_recovering = q.recov;
    assign odd_nibble_seen = q.odd_seen;
    assign link_good_100 = q.link_good;
    assign latched_straps = q.strap_lat;

    assign ctrl.descrambler_cutoff_off = q.fe_cfg[`CUTOFF_OFF_BIT]; // R1
    assign ctrl.descrambler_recovery_ms = q.fe_cfg[`RECOVERY_MSB:`RECOVERY_LSB]; // R2
    assign ctrl.force_good_link = q.fe_cfg[`FORCE_LINK_BIT]; // R3
    assign ctrl.enhanced_ternary_detect_on = q.fe_cfg[`TERNARY_BIT]; // R4
    assign ctrl.enhanced_gap_detect_on = q.fe_cfg[`GAP_BIT]; // R5
    assign ctrl.scrambler_bypass = q.fe_cfg[`SCR_BYPASS_BIT]; // R6
    assign ctrl.odd_nibble_detect_on = q.fe_cfg[`ODD_NIBBLE_BIT]; // R7
    assign ctrl.early_receive_valid = q.fe_cfg[`EARLY_VALID_BIT]; // R8

    // Straps give only the low three code bits, so the delay line sees codes 0 to 7.
    assign tx_delay_code = {1'b0, q.strap_lat.tx_delay_low}; // R22
    assign rx_delay_code = {1'b0, q.strap_lat.rx_delay_low}; // R22

endmodule // phy_config_strap_status

`default_nettype wire

// ### sim/phy_cfg_props.sv
`timescale 1ns/10ps
`default_nettype none

module phy_cfg_props #(
    parameter int CUTOFF_CYCLES = 30000,
    parameter int MS_CYCLES = 20000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire phy_cfg_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rx_active,
    input wire logic descrambler_lost,
    input wire logic link_eval_good,
    input wire phy_cfg_pkg::fe_ctrl_t ctrl,
    input wire logic rx_abort,
    input wire logic descrambler_recovering,
    input wire logic link_good_100,
    input wire phy_cfg_pkg::strap_pins_t latched_straps
);
    // Counters stand in for delays, since the real timer lengths exceed any delay operator.
    int run_q;
    int rec_q;
    int age_q;
    logic [15:0] sts_a;
    logic [15:0] sts_b;
    assign sts_a = {latched_straps[20:12], 1'b0, latched_straps[11], 1'b0, latched_straps[10:7]};
    assign sts_b = {5'h00, latched_straps[6], 3'h0, latched_straps[5:3], 1'b0, latched_straps[2:0]};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= 0;
            rec_q <= 0;
            age_q <= 0;
        end else begin
            run_q <= rx_active ? run_q + 1 : 0;
            age_q <= (age_q < 8) ? age_q + 1 : age_q;
            if (descrambler_lost) rec_q <= int'(ctrl.descrambler_recovery_ms) * MS_CYCLES;
            else if (rec_q != 0) rec_q <= rec_q - 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    cfg_read_a: assert property (req.rd && req.addr == 16'h0043 |=>
        rdata == {4'h0, $past(ctrl[10:3]), 1'b0, $past(ctrl[2:0])}) else $error("config read bad");
    strap_low_read_a: assert property (req.rd && req.addr == 16'h006E |=>
        rdata == $past(sts_a)) else $error("first strap read bad");
    strap_high_read_a: assert property (req.rd && req.addr == 16'h006F |=>
        rdata == $past(sts_b)) else $error("second strap read bad");
    unmapped_zero_a: assert property (req.rd && !(req.addr inside
        {16'h0043, 16'h0055, 16'h006E, 16'h006F}) |=> rdata == 16'h0000) else $error("unmapped read");
    link_force_a: assert property (1'b1 |=>
        link_good_100 == $past(ctrl.force_good_link | link_eval_good)) else $error("link bad");
    straps_held_a: assert property (age_q >= 6 |-> $stable(latched_straps))
        else $error("straps moved");
    abort_time_a: assert property (rx_abort ==
        (run_q == CUTOFF_CYCLES + 1 && !ctrl.descrambler_cutoff_off)) else $error("abort timing");
    recovery_len_a: assert property (descrambler_recovering == (rec_q != 0))
        else $error("recovery length");
endmodule // phy_cfg_props

bind phy_config_strap_status phy_cfg_props #(.CUTOFF_CYCLES(CUTOFF_CYCLES),
    .MS_CYCLES(MS_CYCLES)) i_phy_cfg_props (.clk, .rst_n, .req, .rdata, .rx_active,
    .descrambler_lost, .link_eval_good, .ctrl, .rx_abort, .descrambler_recovering,
    .link_good_100, .latched_straps);

`default_nettype wire

// ### sim/phy_config_strap_status_tb.sv
`timescale 1ns/10ps
`default_nettype none

module phy_config_strap_status_tb;
    localparam int CUT = 20;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    phy_cfg_pkg::reg_req_t req = '0;
    phy_cfg_pkg::strap_pins_t strap_pins = {9'h155, 1'b1, 4'hA, 1'b1, 3'h5, 3'h3};
    logic rx_active = 1'b0;
    logic rx_nibble_valid = 1'b0;
    logic descrambler_lost = 1'b0;
    logic link_eval_good = 1'b0;
    logic sym_ref = 1'b0;
    logic [1:0] pair_sym_start = 2'h0;
    logic [15:0] rdata;
    phy_cfg_pkg::fe_ctrl_t ctrl;
    logic rx_abort, descrambler_recovering, odd_nibble_seen, link_good_100;
    phy_cfg_pkg::strap_pins_t latched_straps;
    logic [3:0] tx_delay_code;
    logic [3:0] rx_delay_code;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] n;

    phy_config_strap_status #(.CUTOFF_CYCLES(CUT), .MS_CYCLES(MS)) i_phy_config_strap_status (
        .clk, .rst_n, .ce, .req, .rdata, .strap_pins, .rx_active, .rx_nibble_valid,
        .descrambler_lost, .link_eval_good, .sym_ref, .pair_sym_start, .ctrl, .rx_abort,
        .descrambler_recovering, .odd_nibble_seen, .link_good_100, .latched_straps,
        .tx_delay_code, .rx_delay_code);

    initial begin
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // The trailing #1 delay keeps two strobes apart in time, yet a read may still follow at once.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic t_reset();
        rd(16'h0043, 16'h07A0);
        rd(16'h0055, 16'h0000);
        rd(16'h006E, 16'hAAAA);
        rd(16'h006F, 16'h0453);
        chk({12'h000, tx_delay_code}, 16'h0005);
        chk({12'h000, rx_delay_code}, 16'h0003);
        chk({12'h000, latched_straps.latched_port_address}, 16'h000A);
        strap_pins <= ~strap_pins;
        settle(6);
        rd(16'h006E, 16'hAAAA);
        rd(16'h006F, 16'h0453);
        $display("test reset done");
    endtask

    task automatic t_cfg();
        logic [15:0] v;
        wr(16'h0055, 16'hFFFF);
        wr(16'h006E, 16'h0000);
        rd(16'h0055, 16'h0000);
        rd(16'h006E, 16'hAAAA);
        rd(16'h0044, 16'h0000);
        wr(16'h0043, 16'hFFFF);
        rd(16'h0043, 16'h0FF7);
        for (int b = 0; b < 12; b++) begin
            v = 16'h0001 << b;
            wr(16'h0043, v);
            rd(16'h0043, v & 16'h0FF7);
            chk({5'h00, ctrl}, {5'h00, v[11:4], v[2:0]});
            chk({15'h0000, ctrl.enhanced_gap_detect_on}, {15'h0000, v[4]});
            chk({15'h0000, ctrl.scrambler_bypass}, {15'h0000, v[2]});
            chk({15'h0000, ctrl.early_receive_valid}, {15'h0000, v[0]});
        end
        $display("test config done");
    endtask

    task automatic t_link();
        wr(16'h0043, 16'h0000);
        link_eval_good <= 1'b1;
        settle(2);
        chk({15'h0000, link_good_100}, 16'h0001);
        link_eval_good <= 1'b0;
        settle(2);
        chk({15'h0000, link_good_100}, 16'h0000);
        wr(16'h0043, 16'h0040);
        settle(1);
        chk({15'h0000, link_good_100}, 16'h0001);
        // A write offered while the enable is low must not be taken.
        ce <= 1'b0;
        wr(16'h0043, 16'h0000);
        ce <= 1'b1;
        rd(16'h0043, 16'h0040);
        $display("test link done");
    endtask

    task automatic t_abort(input logic [15:0] cfg, input int exp);
        wr(16'h0043, cfg);
        rx_active <= 1'b1;
        n = 0;
        repeat (CUT + 10) begin
            settle(1);
            n += rx_abort;
        end
        rx_active <= 1'b0;
        settle(2);
        chk(16'(n), 16'(exp));
        $display("test abort done");
    endtask

    task automatic t_recover(input logic [15:0] cfg, input int exp);
        wr(16'h0043, cfg);
        descrambler_lost <= 1'b1;
        settle(1);
        descrambler_lost <= 1'b0;
        n = 0;
        repeat (3 * MS + 5) begin
            n += descrambler_recovering;
            settle(1);
        end
        chk(16'(n), 16'(exp));
        $display("test recovery done");
    endtask

    task automatic t_odd(input logic [15:0] cfg, input int nib, input int exp);
        wr(16'h0043, cfg);
        rx_active <= 1'b1;
        rx_nibble_valid <= 1'b1;
        settle(nib);
        rx_active <= 1'b0;
        rx_nibble_valid <= 1'b0;
        n = 0;
        repeat (4) begin
            settle(1);
            n += odd_nibble_seen;
        end
        chk(16'(n), 16'(exp));
        $display("test odd nibble done");
    endtask

    task automatic t_skew();
        sym_ref <= 1'b1;
        settle(1);
        sym_ref <= 1'b0;
        settle(2);
        pair_sym_start <= 2'h1;
        settle(1);
        pair_sym_start <= 2'h0;
        settle(1);
        pair_sym_start <= 2'h2;
        settle(1);
        pair_sym_start <= 2'h0;
        rd(16'h0055, 16'h0053);
        $display("test skew done");
    endtask

    // A second reset must clear the skews and take the now inverted straps afresh.
    task automatic t_rearm();
        rst_n <= 1'b0;
        settle(2);
        rst_n <= 1'b1;
        settle(6);
        rd(16'h0043, 16'h07A0);
        rd(16'h0055, 16'h0000);
        rd(16'h006E, 16'h5505);
        rd(16'h006F, 16'h0024);
        chk({12'h000, tx_delay_code}, 16'h0002);
        chk({12'h000, rx_delay_code}, 16'h0004);
        $display("test rearm done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle(6);
        t_reset();
        t_cfg();
        t_link();
        t_abort(16'h0000, 1);
        t_abort(16'h0800, 0);
        t_recover(16'h0100, 2 * MS);
        t_recover(16'h0080, MS);
        t_recover(16'h0000, 0);
        t_odd(16'h0002, 3, 1);
        t_odd(16'h0002, 4, 0);
        t_odd(16'h0000, 3, 0);
        t_skew();
        t_rearm();
        stop_test();
    end
endmodule // phy_config_strap_status_tb

`default_nettype wire
